// *** fcs_stats.sv ***
`timescale 1ns/10ps
module fcs_stats (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receive packet status, one pulse per finished packet
  input  wire logic        rx_done,
  input  wire logic [15:0] rx_len,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_filter_pass,
  input  wire logic        rx_missed,
  // Flow-control recognition for the same packet
  input  wire logic        rx_fc_addr_match,
  input  wire logic        rx_fc_type_match,
  input  wire logic [2:0]  rx_fc_op,
  // Transmit pause events, one pulse per frame sent
  input  wire logic        tx_pause_on_sent,
  input  wire logic        tx_pause_off_sent,
  // Control levels for the MAC
  output logic             rx_enable,
  output logic             tx_enable,
  output logic             long_packet_enable
);

  localparam int NCNT = fcs_pkg::NUM_CNT;

  // Register index of a byte address, or all ones if none
  // The two low address bits are ignored
  function automatic logic [3:0] cnt_index(input logic [15:0] addr);
    logic [15:0] word;
    logic [15:0] rel;
    word = {addr[15:2], 2'b00};
    rel  = word - fcs_pkg::OFF_PAUSE_ON_RX;
    if (word < fcs_pkg::OFF_PAUSE_ON_RX || word > fcs_pkg::OFF_GOOD_RX_PKT) begin
      cnt_index = 4'hF;
    end else begin
      cnt_index = rel[5:2];
    end
  endfunction

  // Merge write data into an old value under byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction

  // Inclusive length range test
  function automatic logic len_in(input logic [15:0] len,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    len_in = (len >= lo) && (len <= hi);
  endfunction

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  logic [2:0]  ctrl_q;
  logic [2:0]  ctrl_d;

  assign rx_enable          = ctrl_q[fcs_pkg::CTRL_RX_EN_BIT];
  assign tx_enable          = ctrl_q[fcs_pkg::CTRL_TX_EN_BIT];
  assign long_packet_enable = ctrl_q[fcs_pkg::CTRL_LPE_BIT];

  // ------------------------------------------------------------------
  // Packet status capture: counters act one cycle after the status
  // pulse, on a frozen copy, so each packet is judged exactly once
  // ------------------------------------------------------------------
  logic        pkt_q;
  logic [15:0] pkt_len_q;
  logic        pkt_crc_ok_q;
  logic        pkt_filter_q;
  logic        pkt_missed_q;
  logic        pkt_fc_q;
  logic [2:0]  pkt_op_q;
  logic        txon_q;
  logic        txoff_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_q        <= 1'b0;
      pkt_len_q    <= 16'h0000;
      pkt_crc_ok_q <= 1'b0;
      pkt_filter_q <= 1'b0;
      pkt_missed_q <= 1'b0;
      pkt_fc_q     <= 1'b0;
      pkt_op_q     <= 3'h0;
      txon_q       <= 1'b0;
      txoff_q      <= 1'b0;
    end else begin
      pkt_q        <= rx_done;
      pkt_len_q    <= rx_len;
      pkt_crc_ok_q <= rx_crc_ok;
      pkt_filter_q <= rx_filter_pass;
      pkt_missed_q <= rx_missed;
      pkt_fc_q     <= rx_fc_addr_match && rx_fc_type_match;
      pkt_op_q     <= rx_fc_op;
      txon_q       <= tx_pause_on_sent;
      txoff_q      <= tx_pause_off_sent;
    end
  end

  // ------------------------------------------------------------------
  // Packet classification
  // ------------------------------------------------------------------
  wire [15:0] len_limit;
  wire        len_legal;
  wire        rx_counting;
  wire        fc_seen;
  wire        good_pkt;
  wire        op_on;
  wire        op_off;
  wire        op_bad;

  assign len_limit   = long_packet_enable ? fcs_pkg::LEN_MAX_LONG
                                          : fcs_pkg::LEN_MAX_STD;
  assign len_legal   = len_in(pkt_len_q, fcs_pkg::LEN_MIN, len_limit);
  assign rx_counting = pkt_q && rx_enable;
  assign fc_seen     = rx_counting && pkt_fc_q;
  assign op_on       = pkt_op_q == fcs_pkg::FCS_OP_ON;
  assign op_off      = pkt_op_q == fcs_pkg::FCS_OP_OFF;
  assign op_bad      = !op_on && !op_off;

  // Good: clean CRC, filtered, legal, not missed, not flow control
  assign good_pkt    = rx_counting && pkt_crc_ok_q && pkt_filter_q && len_legal
                       && !pkt_missed_q && !pkt_fc_q;

  logic [NCNT-1:0] cnt_inc;

  assign cnt_inc[fcs_pkg::IDX_PAUSE_ON_RX]    = fc_seen && op_on;
  assign cnt_inc[fcs_pkg::IDX_PAUSE_ON_TX]    = txon_q && tx_enable;
  assign cnt_inc[fcs_pkg::IDX_PAUSE_OFF_RX]   = fc_seen && op_off;
  assign cnt_inc[fcs_pkg::IDX_PAUSE_OFF_TX]   = txoff_q && tx_enable;
  assign cnt_inc[fcs_pkg::IDX_UNSUP_PAUSE_RX] = fc_seen && op_bad;
  assign cnt_inc[fcs_pkg::IDX_BIN_64]         =
    good_pkt && (pkt_len_q == fcs_pkg::LEN_MIN);
  assign cnt_inc[fcs_pkg::IDX_BIN_127]        =
    good_pkt && len_in(pkt_len_q, 16'h0041, fcs_pkg::LEN_127);
  assign cnt_inc[fcs_pkg::IDX_BIN_255]        =
    good_pkt && len_in(pkt_len_q, fcs_pkg::LEN_128, fcs_pkg::LEN_255);
  assign cnt_inc[fcs_pkg::IDX_BIN_511]        =
    good_pkt && len_in(pkt_len_q, fcs_pkg::LEN_256, fcs_pkg::LEN_511);
  assign cnt_inc[fcs_pkg::IDX_BIN_1023]       =
    good_pkt && len_in(pkt_len_q, fcs_pkg::LEN_512, fcs_pkg::LEN_1023);
  // Upper bound is the legal limit, so 1522 counts here when standard
  assign cnt_inc[fcs_pkg::IDX_BIN_MAX]        =
    good_pkt && len_in(pkt_len_q, fcs_pkg::LEN_1024, len_limit);
  assign cnt_inc[fcs_pkg::IDX_GOOD_RX]        = good_pkt;

  // ------------------------------------------------------------------
  // AXI4-Lite write path: address and data held until both present
  // ------------------------------------------------------------------
  logic        aw_held_q;
  logic [15:0] aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  wire         aw_take;
  wire         w_take;
  wire         do_write;
  wire [3:0]   wr_idx;
  wire         wr_is_cnt;
  wire         wr_is_ctrl;
  wire         wr_hit;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_write      = aw_held_q && w_held_q;
  assign wr_idx        = cnt_index(aw_addr_q);
  assign wr_is_cnt     = wr_idx != 4'hF;
  assign wr_is_ctrl    = aw_addr_q[15:2] == fcs_pkg::OFF_STAT_CTRL[15:2];
  assign wr_hit        = wr_is_cnt || wr_is_ctrl;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 16'h0000;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= fcs_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Byte lanes of a control write merged over the current value
  wire  [31:0] ctrl_merged;

  assign ctrl_merged = merge_strb({29'h0000_0000, ctrl_q}, w_data_q, w_strb_q);
  assign ctrl_d      = (do_write && wr_is_ctrl) ? ctrl_merged[2:0] : ctrl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= fcs_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------------
  // Counter bank; read-only counters ignore writes with an OKAY reply
  // ------------------------------------------------------------------
  logic [31:0] cnt_val [NCNT];
  logic [NCNT-1:0] cnt_load;

  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    // Loop index narrowed on purpose to the index width
    assign cnt_load[i] = do_write && wr_is_cnt && (wr_idx == 4'(i))
                         && fcs_pkg::CNT_WRITABLE[i];
    fcs_counter u_cnt (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .inc        (cnt_inc[i]),
      .load       (cnt_load[i]),
      .load_value (merge_strb(cnt_val[i], w_data_q, w_strb_q)),
      .value_q    (cnt_val[i])
    );
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read path: one cycle from address to data
  // ------------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  wire         ar_take;
  wire [3:0]   rd_idx;
  wire         rd_is_cnt;
  wire         rd_is_ctrl;
  wire [31:0]  rd_word;

  assign s_axi_arready = !rvalid_q;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = cnt_index(s_axi_araddr);
  assign rd_is_cnt     = rd_idx != 4'hF;
  assign rd_is_ctrl    = s_axi_araddr[15:2] == fcs_pkg::OFF_STAT_CTRL[15:2];
  assign rd_word       = rd_is_cnt  ? cnt_val[rd_idx] :
                         rd_is_ctrl ? {29'h0000_0000, ctrl_q} : 32'h0000_0000;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= fcs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= (rd_is_cnt || rd_is_ctrl) ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// *** fcs_pkg.sv ***
package fcs_pkg;

  // Bus geometry
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 32;
  localparam int          STRB_W        = 4;
  localparam int          NUM_CNT       = 12;
  localparam int          IDX_W         = 4;
  localparam int          LEN_W         = 16;

  // Counter and control register offsets
  localparam logic [15:0] OFF_PAUSE_ON_RX     = 16'h4048;
  localparam logic [15:0] OFF_PAUSE_ON_TX     = 16'h404C;
  localparam logic [15:0] OFF_PAUSE_OFF_RX    = 16'h4050;
  localparam logic [15:0] OFF_PAUSE_OFF_TX    = 16'h4054;
  localparam logic [15:0] OFF_UNSUP_PAUSE_RX  = 16'h4058;
  localparam logic [15:0] OFF_RX_LEN_BIN_64   = 16'h405C;
  localparam logic [15:0] OFF_RX_LEN_BIN_127  = 16'h4060;
  localparam logic [15:0] OFF_RX_LEN_BIN_255  = 16'h4064;
  localparam logic [15:0] OFF_RX_LEN_BIN_511  = 16'h4068;
  localparam logic [15:0] OFF_RX_LEN_BIN_1023 = 16'h406C;
  localparam logic [15:0] OFF_RX_LEN_BIN_MAX  = 16'h4070;
  localparam logic [15:0] OFF_GOOD_RX_PKT     = 16'h4074;
  localparam logic [15:0] OFF_STAT_CTRL       = 16'h4100;

  // Counter indices, in address order from the first counter
  localparam int          IDX_PAUSE_ON_RX     = 0;
  localparam int          IDX_PAUSE_ON_TX     = 1;
  localparam int          IDX_PAUSE_OFF_RX    = 2;
  localparam int          IDX_PAUSE_OFF_TX    = 3;
  localparam int          IDX_UNSUP_PAUSE_RX  = 4;
  localparam int          IDX_BIN_64          = 5;
  localparam int          IDX_BIN_127         = 6;
  localparam int          IDX_BIN_255         = 7;
  localparam int          IDX_BIN_511         = 8;
  localparam int          IDX_BIN_1023        = 9;
  localparam int          IDX_BIN_MAX         = 10;
  localparam int          IDX_GOOD_RX         = 11;

  // Counters that software may overwrite
  localparam logic [11:0] CNT_WRITABLE        = 12'h7F0;

  // Control register fields and reset
  localparam int          CTRL_RX_EN_BIT      = 0;
  localparam int          CTRL_TX_EN_BIT      = 1;
  localparam int          CTRL_LPE_BIT        = 2;
  localparam logic [2:0]  CTRL_RESET          = 3'h0;
  localparam logic [31:0] CNT_RESET           = 32'h0000_0000;

  // Frame length limits, destination address through FCS
  localparam logic [15:0] LEN_MIN             = 16'h0040;
  localparam logic [15:0] LEN_127             = 16'h007F;
  localparam logic [15:0] LEN_128             = 16'h0080;
  localparam logic [15:0] LEN_255             = 16'h00FF;
  localparam logic [15:0] LEN_256             = 16'h0100;
  localparam logic [15:0] LEN_511             = 16'h01FF;
  localparam logic [15:0] LEN_512             = 16'h0200;
  localparam logic [15:0] LEN_1023            = 16'h03FF;
  localparam logic [15:0] LEN_1024            = 16'h0400;
  localparam logic [15:0] LEN_MAX_STD         = 16'h05F2;
  localparam logic [15:0] LEN_MAX_LONG        = 16'h4000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_DECERR         = 2'h3;

  // Opcode class of a received flow-control frame
  typedef enum logic [2:0] {
    FCS_OP_ON    = 3'b001,
    FCS_OP_OFF   = 3'b010,
    FCS_OP_BAD   = 3'b100
  } fcs_fc_op_e;

endpackage

// *** fcs_counter.sv ***
`timescale 1ns/10ps
module fcs_counter (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Events and software load
  input  wire logic        inc,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  // Count
  output logic      [31:0] value_q
);

  logic [31:0] base;
  logic [31:0] value_d;

  // A load in the same cycle as an event keeps the event
  assign base    = load ? load_value : value_q;
  assign value_d = base + {31'h0000_0000, inc};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= fcs_pkg::CNT_RESET;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// *** fcs_stats_chk.sv ***
`timescale 1ns/10ps
module fcs_stats_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Control levels
  input wire logic        rx_enable,
  input wire logic        tx_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_reset_state;
    disable iff (1'b0) !aresetn |=> s_axi_awready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid && s_axi_rdata == 32'h0 && !rx_enable && !tx_enable;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad reset state");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write answer");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no read answer");
  property p_write_stall;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write taken early");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
  property p_decerr_zero;
    s_axi_rvalid && s_axi_rresp == fcs_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_decerr_zero: assert property (p_decerr_zero) else $error("unmapped data");
  property p_ctrl_by_write;
    $changed({rx_enable, tx_enable}) |-> ##[0:1] s_axi_bvalid;
  endproperty
  a_ctrl_by_write: assert property (p_ctrl_by_write) else $error("enable moved");
endmodule

// *** fcs_mac_model.sv ***
`timescale 1ns/10ps
module fcs_mac_model (
  // Clock
  input  wire logic        aclk,
  // Packet status
  output logic             rx_done,
  output logic [15:0]      rx_len,
  output logic             rx_crc_ok,
  output logic             rx_filter_pass,
  output logic             rx_missed,
  output logic             rx_fc_addr_match,
  output logic             rx_fc_type_match,
  output logic [2:0]       rx_fc_op,
  // Pause pulses
  output logic             tx_pause_on_sent,
  output logic             tx_pause_off_sent
);
  logic [23:0] st_q = 24'h0;
  logic [2:0]  pulse_q = 3'h0;
  assign {rx_len, rx_crc_ok, rx_filter_pass, rx_missed} = st_q[23:5];
  assign {rx_fc_addr_match, rx_fc_type_match, rx_fc_op} = st_q[4:0];
  assign {rx_done, tx_pause_on_sent, tx_pause_off_sent} = pulse_q;
  task automatic send(input logic d, input logic [15:0] len, input logic [4:0] f,
                      input logic [2:0] op, input logic [1:0] t);
    @(posedge aclk);
    pulse_q <= {d, t};
    st_q    <= {len, f, op};
  endtask
  // Between packets the status shows the inverse so nothing stale looks valid
  task automatic idle;
    @(posedge aclk);
    pulse_q <= 3'h0;
    st_q    <= ~st_q;
  endtask
endmodule

// *** fcs_stats_tb.sv ***
`timescale 1ns/10ps
module fcs_stats_tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rx_done, rx_crc_ok, rx_filter_pass, rx_missed, rx_fc_addr_match;
  logic        rx_fc_type_match, tx_pause_on_sent, tx_pause_off_sent;
  logic        rx_enable, tx_enable, long_packet_enable;
  logic [15:0] rx_len;
  logic [2:0]  rx_fc_op, ctrl;
  logic [31:0] exp_q [12];
  int          bad_count = 0, checked = 0;
  logic [15:0] corner [15] = '{16'h003F, 16'h0040, 16'h0041, 16'h007F, 16'h0080, 16'h00FF,
    16'h0100, 16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05F2, 16'h05F3, 16'h4000, 16'h4001};
  always #20 aclk = ~aclk;
  fcs_stats u_dut (.*);
  fcs_mac_model u_mac (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic check_all;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 12; i++) begin
      rd(16'h4048 + 16'(4 * i), d, r);
      chk(d, exp_q[i]);
      chk(32'(r), 32'(fcs_pkg::RESP_OKAY));
    end
    rd(16'h4100, d, r);
    chk(d, {29'h0, ctrl});
    chk({29'h0, long_packet_enable, tx_enable, rx_enable}, {29'h0, ctrl});
    rd(16'h4200, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(fcs_pkg::RESP_DECERR));
    $display("test step done, checks=%0d", checked);
  endtask
  function automatic logic [11:0] rx_mask(input logic [15:0] len, input logic [4:0] f,
                                          input logic [2:0] op);
    logic [15:0] lim;
    rx_mask = 12'h0;
    lim = ctrl[2] ? 16'h4000 : 16'h05F2;
    if (!ctrl[0])
      return 12'h0;
    if (f[1] && f[0])
      rx_mask[(op == 3'h1) ? 0 : (op == 3'h2) ? 2 : 4] = 1'b1;
    else if (f[4] && f[3] && !f[2] && len >= 16'h0040 && len <= lim) begin
      rx_mask[11] = 1'b1;
      rx_mask[(len == 16'h0040) ? 5 : (len < 16'h0080) ? 6 : (len < 16'h0100) ? 7 :
              (len < 16'h0200) ? 8 : (len < 16'h0400) ? 9 : 10] = 1'b1;
    end
  endfunction
  task automatic pkt(input logic d, input logic [15:0] len, input logic [4:0] f,
                     input logic [2:0] op, input logic [1:0] t);
    logic [11:0] m;
    m = d ? rx_mask(len, f, op) : 12'h0;
    m[1] = t[1] & ctrl[1];
    m[3] = t[0] & ctrl[1];
    u_mac.send(d, len, f, op, t);
    for (int i = 0; i < 12; i++)
      exp_q[i] += 32'(m[i]);
  endtask
  task automatic traffic(input int n);
    logic [4:0] f;
    for (int i = 0; i < 15; i++)
      pkt(1'b1, corner[i], 5'h18, 3'h1, 2'h0);
    for (int i = 0; i < 8; i++)
      pkt(1'b1, 16'h0040, 5'h1B, 3'(i), 2'(i));
    pkt(1'b1, 16'h0100, 5'h1C, 3'h0, 2'h3);
    pkt(1'b1, 16'h0080, 5'h1A, 3'h1, 2'h0);
    for (int i = 0; i < n; i++) begin
      f = 5'($urandom);
      if (f[1] && f[0])
        f[2] = 1'b0;
      pkt(1'($urandom), 16'($urandom_range(40, 1700)), f, 3'($urandom), 2'($urandom));
    end
    u_mac.idle();
    repeat (4) @(posedge aclk);
  endtask
  task automatic set_ctrl(input logic [2:0] c);
    wr(16'h4100, {29'h0, c}, 4'hF, fcs_pkg::RESP_OKAY);
    ctrl = c;
  endtask
  initial begin
    logic [31:0] v;
    logic [3:0]  s;
    v = $urandom(32'h70B9);
    ctrl = 3'h0;
    for (int i = 0; i < 12; i++)
      exp_q[i] = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    check_all();
    traffic(20);
    check_all();
    set_ctrl(3'h3);
    traffic(150);
    check_all();
    set_ctrl(3'h7);
    traffic(150);
    check_all();
    set_ctrl(3'h2);
    traffic(30);
    check_all();
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      s = 4'($urandom);
      wr(16'h4048 + 16'(4 * i), v, s, fcs_pkg::RESP_OKAY);
      for (int b = 0; b < 4; b++)
        if (12'h7F0 >> i & 12'h1 && s[b])
          exp_q[i][8 * b +: 8] = v[8 * b +: 8];
    end
    wr(16'h4300, 32'h1, 4'hF, fcs_pkg::RESP_DECERR);
    check_all();
    finish_test();
  end
  initial begin
    #(40 * 20000);
    bad_count++;
    finish_test();
  end
endmodule
bind fcs_stats fcs_stats_chk u_chk (.*);
